// ==== pkg/sprx_params.svh ====
`ifndef SPRX_PARAMS_SVH
`define SPRX_PARAMS_SVH

// Register addresses on the control port (7-bit address, 9-bit data)
`define SPRX_ADDR_MASK 7'h25
`define SPRX_ADDR_GP1 7'h26
`define SPRX_ADDR_GP2 7'h27
`define SPRX_ADDR_GP3 7'h28
`define SPRX_ADDR_GP4 7'h29
`define SPRX_ADDR_STAT 7'h31

// Reset values
`define SPRX_RST_MASK 9'h000
`define SPRX_RST_GP1 9'h010
`define SPRX_RST_GP2 9'h032
`define SPRX_RST_GP3 9'h054
`define SPRX_RST_GP4 9'h006

// Field positions
`define SPRX_BIT_FILL 8
`define SPRX_BIT_IGNV 8
`define SPRX_MB_INVALID 1
`define SPRX_MB_CORRUPT 3
`define SPRX_MB_NONLIN 4
`define SPRX_MB_BURST 5

// Burst sync pattern: zero words before Pa/Pb
`define SPRX_SYNC_ZEROS 4

`endif

// ==== pkg/sprx_pkg.sv ====
package sprx_pkg;
	typedef enum logic [3:0] {
		SPRX_SEL_IRQ = 4'h0,
		SPRX_SEL_V = 4'h1,
		SPRX_SEL_U = 4'h2,
		SPRX_SEL_C = 4'h3,
		SPRX_SEL_P = 4'h4,
		SPRX_SEL_SUBFRAME = 4'h5,
		SPRX_SEL_BLK = 4'h6,
		SPRX_SEL_UNLOCK = 4'h7,
		SPRX_SEL_CS_UPDATE = 4'h8,
		SPRX_SEL_INVALID = 4'h9,
		SPRX_SEL_ZERO = 4'hA,
		SPRX_SEL_COMP = 4'hB,
		SPRX_SEL_COPY = 4'hC,
		SPRX_SEL_PREEMP = 4'hD,
		SPRX_SEL_CMOS_IN = 4'hE,
		SPRX_SEL_COMP_IN = 4'hF
	} sprx_sel_t;

	typedef enum logic [1:0] {
		SPRX_SY_ZERO = 2'b00,
		SPRX_SY_PA = 2'b01,
		SPRX_SY_PB = 2'b10
	} sprx_sync_t;
endpackage

// ==== src/sprx_pin_mux.sv ====
`timescale 1ns/100ps
// One configurable status output pin
module sprx_pin_mux
	import sprx_pkg::*;
#(
	parameter bit CAN_INPUT = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Selection and sources
	input wire logic [3:0] sel_i,
	input wire logic [13:0] src_i,
	// Pin
	output logic pin_o,
	output logic pin_oe_o,
	output logic rx_sel_o,
	output logic rx_comp_o
);
	logic pin_q;
	logic is_in;

	// input codes on capable pins only
	assign is_in = CAN_INPUT && (sel_i == SPRX_SEL_CMOS_IN ||
		sel_i == SPRX_SEL_COMP_IN);
	assign rx_comp_o = is_in && sel_i == SPRX_SEL_COMP_IN;
	assign rx_sel_o = is_in && sel_i == SPRX_SEL_CMOS_IN;
	assign pin_oe_o = !is_in;
	assign pin_o = pin_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_q <= 1'b0;
		end else if (sel_i < 4'hE) begin
			pin_q <= src_i[sel_i];
		end else begin
			pin_q <= 1'b0;
		end
	end
endmodule

// ==== src/sprx_post.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - Corrupt flag set on biphase, parity or preamble error of a subframe.
// - Invalid flag set from validity bit; both flags count as errors.
// - Unmasked error flags: samples forwarded unchanged to all paths.
// - Unmasked errors drive the active-low interrupt output.
// - Masked error with conceal select 1: sample replaced by zeros.
// - Masked error with conceal select 0: repeat last good sample.
// - Ignore-validity 1 disables concealment for the invalid flag.
// - Transmitter path overwritten only for invalid, never corrupt.
// - Burst-sync bit set on four zero words then Pa, Pb.
// - Non-linear status is channel status bit 1.
// - Compressed-payload indication is burst-sync OR non-linear.
// - Soft-mute first DAC path when it sources receiver and compressed.
// - Each burst-sync or non-linear change interrupts unless masked.
// - Masked payload status still mutes the first DAC path.
// - Four-bit selector chooses each output pin source.
// - Code 1110 makes pins 3 to 5 a CMOS receiver input.
// - Code 1111 makes pins 3 to 5 a comparator receiver input.
// - Seven pins; after reset they select codes 0 to 6.
// - Masked flag neither interrupts nor sets interrupt status; 1 masks.
// - Mask bits: 1 invalid, 3 corrupt, 4 non-linear, 5 burst-sync.
`include "sprx_params.svh"
module sprx_post
	import sprx_pkg::*;
#(
	parameter int SW = 24,
	parameter logic [15:0] PA_WORD = 16'hF872,
	parameter logic [15:0] PB_WORD = 16'h4E1F
) (
	// System clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Receiver link domain
	input wire logic link_clk_i,
	input wire logic sf_valid_i,
	input wire logic sf_right_i,
	input wire logic [SW-1:0] sf_data_i,
	input wire logic sf_biphase_err_i,
	input wire logic sf_parity_err_i,
	input wire logic sf_preamble_err_i,
	input wire logic sf_v_i,
	input wire logic sf_u_i,
	input wire logic sf_c_i,
	input wire logic sf_block_start_i,
	// Receiver status levels (other blocks)
	input wire logic unlock_i,
	input wire logic chan_status_update_i,
	input wire logic [3:0] cs_bits_i,
	input wire logic zero_detect_i,
	// Control port
	input wire logic reg_wr_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [8:0] reg_wdata_i,
	output logic [8:0] reg_rdata_o,
	// Routing
	input wire logic first_dac_src_rx_i,
	// Audio outputs, system domain
	output logic out_valid_o,
	output logic out_right_o,
	output logic [SW-1:0] aif_data_o,
	output logic [SW-1:0] tx_data_o,
	output logic first_dac_path_mute_o,
	output logic irq_n_o,
	output logic burst_sync_o,
	output logic non_linear_o,
	// Output pins 1..7
	output logic [6:0] gpo_o,
	output logic [6:0] gpo_oe_o,
	output logic [2:0] rx_input_sel_o,
	output logic [2:0] rx_input_comp_o
);
	// ---------------- Link domain ----------------
	logic [SW-1:0] l_data_q;
	logic l_right_q;
	logic l_corrupt_q;
	logic l_invalid_q;
	logic l_v_q;
	logic l_u_q;
	logic l_c_q;
	logic l_p_q;
	logic l_blk_q;
	logic l_tog_q;
	logic l_burst_q;
	sprx_sync_t l_sy_q;
	logic [2:0] l_zc_q;
	logic [15:0] l_word;

	assign l_word = sf_data_i[SW-1 -: 16];

	// Capture a whole subframe; handed over by toggle
	always_ff @(posedge link_clk_i) begin
		if (rst_i) begin
			l_data_q <= '0;
			l_right_q <= 1'b0;
			l_corrupt_q <= 1'b0;
			l_invalid_q <= 1'b0;
			l_v_q <= 1'b0;
			l_u_q <= 1'b0;
			l_c_q <= 1'b0;
			l_p_q <= 1'b0;
			l_blk_q <= 1'b0;
			l_tog_q <= 1'b0;
		end else if (sf_valid_i) begin
			l_data_q <= sf_data_i;
			l_right_q <= sf_right_i;
			l_corrupt_q <= sf_biphase_err_i | sf_parity_err_i |
				sf_preamble_err_i;
			l_invalid_q <= sf_v_i;
			l_v_q <= sf_v_i;
			l_u_q <= sf_u_i;
			l_c_q <= sf_c_i;
			l_p_q <= sf_parity_err_i;
			l_blk_q <= sf_block_start_i;
			l_tog_q <= ~l_tog_q;
		end
	end

	// burst sync search on the upper 16 bits
	always_ff @(posedge link_clk_i) begin
		if (rst_i) begin
			l_sy_q <= SPRX_SY_ZERO;
			l_zc_q <= 3'h0;
			l_burst_q <= 1'b0;
		end else if (sf_valid_i) begin
			case (l_sy_q)
				SPRX_SY_ZERO: begin
					if (l_word == 16'h0000) begin
						if (l_zc_q != 3'(`SPRX_SYNC_ZEROS))
							l_zc_q <= l_zc_q + 3'h1;
					end else if (l_zc_q == 3'(`SPRX_SYNC_ZEROS) &&
						l_word == PA_WORD) begin
						l_sy_q <= SPRX_SY_PB;
					end else begin
						l_zc_q <= 3'h0;
						l_burst_q <= 1'b0;
					end
				end
				SPRX_SY_PB: begin
					l_sy_q <= SPRX_SY_ZERO;
					l_zc_q <= 3'h0;
					l_burst_q <= (l_word == PB_WORD);
				end
				default: begin
					l_sy_q <= SPRX_SY_ZERO;
					l_zc_q <= 3'h0;
				end
			endcase
		end
	end

	// ---------------- Crossing ----------------
	logic [2:0] tog_s_q;
	logic [1:0] burst_s_q;
	logic new_sf;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tog_s_q <= 3'h0;
			burst_s_q <= 2'h0;
		end else begin
			tog_s_q <= {tog_s_q[1:0], l_tog_q};
			burst_s_q <= {burst_s_q[0], l_burst_q};
		end
	end
	// Link word is stable for a subframe, far longer than sync delay
	assign new_sf = tog_s_q[2] ^ tog_s_q[1];

	// Status levels from pins or other clocks
	logic [6:0] st_s1_q;
	logic [6:0] st_s2_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_s1_q <= 7'h00;
			st_s2_q <= 7'h00;
		end else begin
			st_s1_q <= {unlock_i, chan_status_update_i, cs_bits_i,
				zero_detect_i};
			st_s2_q <= st_s1_q;
		end
	end

	// ---------------- Registers ----------------
	logic [8:0] mask_q;
	logic [8:0] gp1_q;
	logic [8:0] gp2_q;
	logic [8:0] gp3_q;
	logic [8:0] gp4_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mask_q <= `SPRX_RST_MASK;
			gp1_q <= `SPRX_RST_GP1;
			gp2_q <= `SPRX_RST_GP2;
			gp3_q <= `SPRX_RST_GP3;
			gp4_q <= `SPRX_RST_GP4;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`SPRX_ADDR_MASK: mask_q <= reg_wdata_i;
				`SPRX_ADDR_GP1: gp1_q <= reg_wdata_i;
				`SPRX_ADDR_GP2: gp2_q <= reg_wdata_i;
				`SPRX_ADDR_GP3: gp3_q <= reg_wdata_i;
				`SPRX_ADDR_GP4: gp4_q <= {5'h00, reg_wdata_i[3:0]};
				default: ;
			endcase
		end
	end

	logic burst_q;
	logic nonlin_q;
	logic cpy_q;
	logic preemp_q;
	logic m_inv;
	logic m_cor;

	assign m_inv = mask_q[`SPRX_MB_INVALID];
	assign m_cor = mask_q[`SPRX_MB_CORRUPT];

	// Status bits read back with unlock
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 9'h000;
		end else begin
			case (reg_addr_i)
				`SPRX_ADDR_MASK: reg_rdata_o <= mask_q;
				`SPRX_ADDR_GP1: reg_rdata_o <= gp1_q;
				`SPRX_ADDR_GP2: reg_rdata_o <= gp2_q;
				`SPRX_ADDR_GP3: reg_rdata_o <= gp3_q;
				`SPRX_ADDR_GP4: reg_rdata_o <= gp4_q;
				`SPRX_ADDR_STAT: reg_rdata_o <= {2'h0, st_s2_q[6], 2'h0,
					preemp_q, cpy_q, burst_q, nonlin_q};
				default: reg_rdata_o <= 9'h000;
			endcase
		end
	end

	// ---------------- Concealment ----------------
	logic [SW-1:0] last_l_q;
	logic [SW-1:0] last_r_q;
	logic [SW-1:0] last_ch;
	logic inv_conceal;
	logic cor_conceal;
	logic conceal;
	logic fill_zero;
	logic [6:0] sf_st_q;

	assign fill_zero = gp1_q[`SPRX_BIT_FILL];
	assign inv_conceal = l_invalid_q && m_inv && !gp2_q[`SPRX_BIT_IGNV];
	assign cor_conceal = l_corrupt_q && m_cor;
	assign conceal = inv_conceal || cor_conceal;
	assign last_ch = l_right_q ? last_r_q : last_l_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			last_l_q <= '0;
			last_r_q <= '0;
		end else if (new_sf && !l_corrupt_q && !l_invalid_q) begin
			if (l_right_q)
				last_r_q <= l_data_q;
			else
				last_l_q <= l_data_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			out_valid_o <= 1'b0;
			out_right_o <= 1'b0;
			sf_st_q <= 7'h00;
			aif_data_o <= '0;
			tx_data_o <= '0;
		end else begin
			out_valid_o <= new_sf;
			if (new_sf) begin
				out_right_o <= l_right_q;
				// Pin copies of link bits, taken only once settled
				sf_st_q <= {l_invalid_q, l_blk_q, l_right_q, l_p_q,
					l_c_q, l_u_q, l_v_q};
				if (!conceal)
					aif_data_o <= l_data_q;
				else if (fill_zero)
					aif_data_o <= '0;
				else
					aif_data_o <= last_ch;
				if (!inv_conceal)
					tx_data_o <= l_data_q;
				else if (fill_zero)
					tx_data_o <= '0;
				else
					tx_data_o <= last_ch;
			end
		end
	end

	// ---------------- Payload status ----------------
	logic comp;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			burst_q <= 1'b0;
			nonlin_q <= 1'b0;
			cpy_q <= 1'b0;
			preemp_q <= 1'b0;
		end else begin
			burst_q <= burst_s_q[1];
			nonlin_q <= st_s2_q[1];
			cpy_q <= st_s2_q[2];
			preemp_q <= st_s2_q[3];
		end
	end
	assign comp = burst_q | nonlin_q;
	assign burst_sync_o = burst_q;
	assign non_linear_o = nonlin_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			first_dac_path_mute_o <= 1'b0;
		else
			first_dac_path_mute_o <= first_dac_src_rx_i && comp;
	end

	// ---------------- Interrupt ----------------
	logic burst_d1_q;
	logic nonlin_d1_q;
	logic irq_q;
	logic ev_err;
	logic ev_pay;

	// unmasked errors interrupt; masked ones do not
	assign ev_err = new_sf && ((l_invalid_q && !m_inv) ||
		(l_corrupt_q && !m_cor));
	assign ev_pay = ((burst_q ^ burst_d1_q) && !mask_q[`SPRX_MB_BURST]) ||
		((nonlin_q ^ nonlin_d1_q) && !mask_q[`SPRX_MB_NONLIN]);

	// Held until any register write; a new event wins over the clear
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			burst_d1_q <= 1'b0;
			nonlin_d1_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			burst_d1_q <= burst_q;
			nonlin_d1_q <= nonlin_q;
			if (ev_err || ev_pay)
				irq_q <= 1'b1;
			else if (reg_wr_i)
				irq_q <= 1'b0;
		end
	end
	assign irq_n_o = ~irq_q;

	// ---------------- Output pins ----------------
	logic [13:0] src;
	logic [3:0] sel [7];
	logic [2:0] in_sel;
	logic [2:0] in_comp;

	assign src = {preemp_q, cpy_q, comp, st_s2_q[0], sf_st_q[6],
		st_s2_q[5], st_s2_q[6], sf_st_q[5:0], irq_n_o};
	assign sel[0] = gp1_q[3:0];
	assign sel[1] = gp1_q[7:4];
	assign sel[2] = gp2_q[3:0];
	assign sel[3] = gp2_q[7:4];
	assign sel[4] = gp3_q[3:0];
	assign sel[5] = gp3_q[7:4];
	assign sel[6] = gp4_q[3:0];

	for (genvar i = 0; i < 7; i++) begin : g_pin
		logic rs;
		logic rc;
		sprx_pin_mux #(
			.CAN_INPUT((i >= 2) && (i <= 4))
		) u_pin (
			.ref_clk_i(ref_clk_i),
			.rst_i(rst_i),
			.sel_i(sel[i]),
			.src_i(src),
			.pin_o(gpo_o[i]),
			.pin_oe_o(gpo_oe_o[i]),
			.rx_sel_o(rs),
			.rx_comp_o(rc)
		);
		if (i >= 2 && i <= 4) begin : g_in
			assign in_sel[i-2] = rs;
			assign in_comp[i-2] = rc;
		end
	end
	assign rx_input_sel_o = in_sel;
	assign rx_input_comp_o = in_comp;
endmodule

// ==== verif/sprx_post_props.sv ====
`timescale 1ns/100ps
`include "sprx_params.svh"
module sprx_post_props (
	// Clock, reset, control port
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [8:0] reg_wdata_i,
	input wire logic [8:0] reg_rdata_o,
	// Status and pins
	input wire logic [3:0] cs_bits_i,
	input wire logic first_dac_src_rx_i,
	input wire logic first_dac_path_mute_o,
	input wire logic irq_n_o,
	input wire logic burst_sync_o,
	input wire logic non_linear_o,
	input wire logic [6:0] gpo_oe_o,
	input wire logic [2:0] rx_input_sel_o,
	input wire logic [2:0] rx_input_comp_o
);
	logic [8:0] mask_q;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// Shadow of the mask so the properties know what is masked
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mask_q <= 9'h000;
		end else if (reg_wr_i && reg_addr_i == `SPRX_ADDR_MASK) begin
			mask_q <= reg_wdata_i;
		end
	end
	sequence s_mask_wr;
		reg_wr_i && reg_addr_i == `SPRX_ADDR_MASK;
	endsequence
	sequence s_idle;
		!reg_wr_i && $stable(reg_addr_i);
	endsequence
	AST_MASK_RDBK: assert property (
		s_mask_wr ##1 s_idle |=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("mask readback differs");
	AST_IRQ_MASKED: assert property (
		mask_q == 9'h1FF && irq_n_o |=> irq_n_o)
		else $error("masked flag raised irq");
	AST_IRQ_PAYLOAD: assert property (
		($changed(non_linear_o) && !mask_q[4]) ||
		($changed(burst_sync_o) && !mask_q[5]) |-> ##[0:3] !irq_n_o)
		else $error("payload change without irq");
	AST_MUTE_ON: assert property (
		first_dac_src_rx_i && (burst_sync_o || non_linear_o)
		|-> ##[0:4] first_dac_path_mute_o)
		else $error("compressed payload not muted");
	AST_MUTE_OFF: assert property (
		!first_dac_src_rx_i [*4] |-> !first_dac_path_mute_o)
		else $error("mute without receiver source");
	AST_NL_FOLLOW: assert property (
		$stable(cs_bits_i[0]) [*5] |-> non_linear_o == cs_bits_i[0])
		else $error("non-linear status wrong");
	AST_OE_FIXED: assert property (
		&{gpo_oe_o[6:5], gpo_oe_o[1:0]})
		else $error("output-only pin released");
	AST_IN_EXCL: assert property (
		(rx_input_sel_o & rx_input_comp_o) == 3'h0)
		else $error("both input kinds selected");
	AST_OE_IN: assert property (
		$stable(rx_input_sel_o) && $stable(rx_input_comp_o)
		|-> gpo_oe_o[4:2] == ~(rx_input_sel_o | rx_input_comp_o))
		else $error("input pin still driven");
endmodule

bind sprx_post sprx_post_props i_props (.ref_clk_i, .rst_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cs_bits_i, .first_dac_src_rx_i,
	.first_dac_path_mute_o, .irq_n_o, .burst_sync_o, .non_linear_o,
	.gpo_oe_o, .rx_input_sel_o, .rx_input_comp_o);

// ==== verif/sprx_post_tb_top.sv ====
`timescale 1ns/100ps
`include "sprx_params.svh"
module sprx_post_tb_top
	import sprx_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b1;
	logic link_clk_i, sf_valid_i, sf_right_i, sf_block_start_i;
	logic unlock_i, chan_status_update_i, zero_detect_i, reg_wr_i;
	logic first_dac_src_rx_i, out_valid_o, first_dac_path_mute_o, irq_n_o;
	logic burst_sync_o, non_linear_o, out_right_o;
	logic qr[$];
	logic [2:0] err, vuc, rx_input_sel_o, rx_input_comp_o;
	logic [3:0] cs_bits_i;
	logic [6:0] reg_addr_i, gpo_o, gpo_oe_o;
	logic [8:0] reg_wdata_i, reg_rdata_o, msk, gp1, gp2, d;
	logic [23:0] sf_data_i, aif_data_o, tx_data_o;
	logic [23:0] qa[$], qt[$], last[2];
	logic [15:0] sy[6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hF872, 16'h4E1F};
	logic [6:0] ra[6] = '{7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h30};
	logic [8:0] rv[6] = '{9'h000, 9'h010, 9'h032, 9'h054, 9'h006, 9'h000};
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	sprx_post #(.PA_WORD(16'hF872), .PB_WORD(16'h4E1F)) i_dut (.ref_clk_i,
		.rst_i, .link_clk_i, .sf_valid_i, .sf_right_i, .sf_data_i,
		.sf_biphase_err_i(err[0]), .sf_parity_err_i(err[1]),
		.sf_preamble_err_i(err[2]), .sf_v_i(vuc[0]), .sf_u_i(vuc[1]),
		.sf_c_i(vuc[2]), .sf_block_start_i, .unlock_i, .chan_status_update_i,
		.cs_bits_i, .zero_detect_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .first_dac_src_rx_i, .out_valid_o, .out_right_o,
		.aif_data_o, .tx_data_o, .first_dac_path_mute_o, .irq_n_o,
		.burst_sync_o, .non_linear_o, .gpo_o, .gpo_oe_o, .rx_input_sel_o,
		.rx_input_comp_o);
	sprx_src_model i_src (.run_i(run), .link_clk_o(link_clk_i),
		.sf_valid_o(sf_valid_i), .sf_right_o(sf_right_i),
		.sf_data_o(sf_data_i), .sf_err_o(err), .sf_vuc_o(vuc),
		.sf_block_start_o(sf_block_start_i));
	always #20 ref_clk_i = ~ref_clk_i;
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	// Scoreboard: oldest note against each delivered sample
	always @(posedge ref_clk_i) begin
		if (out_valid_o === 1'b1) begin
			if (qa.size() == 0) begin
				chk(24'h1, 24'h0);
			end else begin
				chk(aif_data_o, qa.pop_front());
				chk(tx_data_o, qt.pop_front());
				chk(out_right_o, qr.pop_front());
			end
		end
	end
	task automatic wr(input logic [6:0] a, input logic [8:0] v);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [8:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		#1 chk(reg_rdata_o, e);
	endtask
	task automatic sf(input logic r, input logic [23:0] v24,
		input logic [2:0] e, input logic v);
		logic bt, ba;
		logic [23:0] f;
		bt = v && msk[1] && !gp2[8];
		ba = bt || (|e && msk[3]);
		f = gp1[8] ? 24'h0 : last[r];
		qa.push_back(ba ? f : v24);
		qt.push_back(bt ? f : v24);
		qr.push_back(r);
		if (!(|e) && !v) begin
			last[r] = v24;
		end
		i_src.send(r, v24, e, {2'($urandom), v});
		repeat (4) @(posedge ref_clk_i);
		#1 chk(irq_n_o, !(|e && !msk[3] || v && !msk[1]));
		wr(`SPRX_ADDR_MASK, msk);
	endtask
	initial begin
		void'($urandom(32'hdb14));
		{reg_wr_i, reg_addr_i, reg_wdata_i} = '0;
		{unlock_i, chan_status_update_i, zero_detect_i} = 3'h0;
		cs_bits_i = 4'h0;
		first_dac_src_rx_i = 1'b1;
		last = '{24'h0, 24'h0};
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		run <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], rv[i]);
		end
		foreach (ra[i]) begin
			d = 9'($urandom);
			wr(ra[i], d);
			rd(ra[i], i == 5 ? 9'h0 : i == 4 ? {5'h0, d[3:0]} : d);
		end
		// Static sources so pin levels are predictable
		{unlock_i, zero_detect_i} <= 2'h3;
		cs_bits_i <= 4'h6;
		for (int k = 0; k < 16; k++) begin
			wr(`SPRX_ADDR_GP1, {5'h0, 4'(k)});
			wr(`SPRX_ADDR_GP2, {5'h0, 4'(k)});
			repeat (5) @(posedge ref_clk_i);
			#1 chk(rx_input_sel_o[0], k == SPRX_SEL_CMOS_IN);
			chk(rx_input_comp_o[0], k == SPRX_SEL_COMP_IN);
			chk(gpo_oe_o[0], 1'b1);
			if (16'h3D80 & (16'h1 << k)) begin
				chk(gpo_o[2], 16'h3480 >> k & 16'h1);
			end
		end
		for (int m = 0; m < 4; m++) begin
			msk = m == 0 ? 9'h000 : 9'h00A;
			gp1 = {m == 1, 8'h10};
			gp2 = {m == 3, 8'h32};
			wr(`SPRX_ADDR_GP1, gp1);
			wr(`SPRX_ADDR_GP2, gp2);
			wr(`SPRX_ADDR_MASK, msk);
			for (int j = 0; j < 16; j++) begin
				sf(j[0], 24'($urandom), 3'(4'h8 >> j[2:1]), j[3]);
			end
		end
		msk = 9'h000;
		wr(`SPRX_ADDR_MASK, msk);
		cs_bits_i <= 4'h1;
		repeat (8) @(posedge ref_clk_i);
		#1 chk(non_linear_o, 1'b1);
		chk(first_dac_path_mute_o, 1'b1);
		chk(irq_n_o, 1'b0);
		first_dac_src_rx_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		#1 chk(first_dac_path_mute_o, 1'b0);
		msk = 9'h1FF;
		wr(`SPRX_ADDR_MASK, msk);
		first_dac_src_rx_i <= 1'b1;
		cs_bits_i <= 4'h0;
		foreach (sy[i]) begin
			sf(i[0], {sy[i], 8'h00}, 3'h0, 1'b0);
		end
		repeat (4) @(posedge ref_clk_i);
		#1 chk(burst_sync_o, 1'b1);
		chk(first_dac_path_mute_o, 1'b1);
		chk(irq_n_o, 1'b1);
		end_sim();
	end
endmodule

// ==== verif/sprx_src_model.sv ====
`timescale 1ns/100ps
module sprx_src_model (
	// Control
	input wire logic run_i,
	// Link side
	output logic link_clk_o,
	output logic sf_valid_o,
	output logic sf_right_o,
	output logic [23:0] sf_data_o,
	output logic [2:0] sf_err_o,
	output logic [2:0] sf_vuc_o,
	output logic sf_block_start_o
);
	logic busy = 1'b0;
	initial begin
		link_clk_o = 1'b0;
		sf_valid_o = 1'b0;
		sf_right_o = 1'b0;
		sf_data_o = 24'h0;
		sf_err_o = 3'h0;
		sf_vuc_o = 3'h0;
		sf_block_start_o = 1'b0;
	end
	// Recovered clock stands still between frames
	always #7.5 link_clk_o = (run_i || busy) ? ~link_clk_o : 1'b0;
	task automatic send(input logic r, input logic [23:0] d,
		input logic [2:0] e, input logic [2:0] vuc);
		busy = 1'b1;
		@(posedge link_clk_o);
		sf_valid_o <= 1'b1;
		sf_right_o <= r;
		sf_data_o <= d;
		sf_err_o <= e;
		sf_vuc_o <= vuc;
		sf_block_start_o <= !r && d[0];
		@(posedge link_clk_o);
		sf_valid_o <= 1'b0;
		sf_right_o <= ~r;
		sf_data_o <= ~d;
		sf_err_o <= ~e;
		sf_vuc_o <= ~vuc;
		repeat (8) @(posedge link_clk_o);
		busy = 1'b0;
	endtask
endmodule
